/* File: core/bbri_core.sv */
// Board bus interface with processor clock phases and refresh handshake
`timescale 1ns/1ns

// Functional notes
// - The direction line is high for a memory read, low for a write.
// - With no transfer running the direction line rests high.
// - While halted the direction line stays high.
// - Without debug module the user address line carries valid address.
// - A low refresh request starts a refresh cycle.
// - Both processor clock phases are stopped throughout a refresh.
// - The memory clock keeps running through a refresh.
// - A high refresh grant orders the memory modules to refresh.
// - The address bus is sixteen bits wide, bits 0 to 15.
// - Halt at a boundary sets bus available, clears valid, frees buses.
module bbri_core (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Processor side
	input bbri_pkg::bbri_req_t cpu_req,
	output logic cpu_ready,
	output bbri_pkg::bbri_rsp_t cpu_rsp,
	// Clock circuit
	output logic phase1,
	output logic phase2,
	output logic memory_clock,
	// Control pins
	input wire logic go_halt,
	input wire logic debug_strap,
	input wire logic refresh_request_n,
	output logic refresh_grant,
	output logic bus_available,
	output logic read_write,
	output logic valid_memory_address,
	output logic user_address_valid,
	// Valid user address pin, three signals
	input wire logic valid_user_address_in,
	output logic valid_user_address_out,
	output logic valid_user_address_oe_n,
	// Address bus
	output logic [bbri_pkg::BBRI_ADDR_W-1:0] addr_out,
	output logic addr_oe_n,
	// Data bus, three signals
	input wire logic [bbri_pkg::BBRI_DATA_W-1:0] data_in,
	output logic [bbri_pkg::BBRI_DATA_W-1:0] data_out,
	output logic data_oe_n
);
	import bbri_pkg::*;

	bbri_state_t r;
	bbri_state_t n;
	logic boundary;
	logic booted;
	logic accept;

	// Checks below all run on the one clock
	default clocking bbri_cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// Phase decode from a step count
	function automatic logic in_span(input logic [2:0] s,
		input logic [2:0] lo, input logic [2:0] hi);
		in_span = (s >= lo) && (s <= hi);
	endfunction : in_span

	// Cycle boundary and request acceptance
	assign boundary = (r.step == BBRI_STEP_LAST);
	assign booted = (r.boot == BBRI_BOOT_DONE);
	assign cpu_ready = booted && boundary && (r.mode != BBRI_REFRESH) &&
		r.ref_s2 && r.halt_s2;
	assign accept = cpu_ready && cpu_req.valid;

	// Next state
	always_comb begin
		n = r;
		n.ref_s1 = refresh_request_n;
		n.ref_s2 = r.ref_s1;
		n.halt_s1 = go_halt;
		n.halt_s2 = r.halt_s1;
		n.strap_s1 = debug_strap;
		n.strap_s2 = r.strap_s1;
		n.uaddr_s1 = valid_user_address_in;
		n.uaddr_s2 = r.uaddr_s1;
		n.din_s1 = data_in;
		n.din_s2 = r.din_s1;
		n.mclk = ~r.mclk;
		n.rsp.valid = 1'b0;
		// Strap caught once, after the synchroniser has filled
		if (!booted) begin
			n.boot = r.boot + 2'h1;
		end
		if (r.boot == BBRI_BOOT_CATCH) begin
			n.dbg = r.strap_s2;
		end
		case (r.mode)
			BBRI_REFRESH: begin
				n.phi1 = 1'b0;
				n.phi2 = 1'b0;
				if (r.ref_s2) begin
					n.grant = 1'b0;
					n.mode = BBRI_RUN;
				end else begin
					n.grant = 1'b1;
				end
			end
			BBRI_RUN, BBRI_HALT: begin
				n.step = r.step + 3'h1;
				n.phi1 = in_span(n.step, BBRI_PHI1_FIRST, BBRI_PHI1_END);
				n.phi2 = in_span(n.step, BBRI_PHI2_FIRST, BBRI_PHI2_END);
				if (boundary) begin
					// Close the running transfer
					if (r.busy) begin
						n.busy = 1'b0;
						n.mem_valid = 1'b0;
						n.rw = 1'b1;
						n.rsp.valid = 1'b1;
						if (!r.wr) begin
							n.rsp.rdata = r.din_s2;
						end
					end
					if (!r.ref_s2) begin
						n.mode = BBRI_REFRESH;
						n.step = r.step;
						n.phi1 = 1'b0;
						n.phi2 = 1'b0;
					end else if (!r.halt_s2) begin
						n.mode = BBRI_HALT;
						n.ba = 1'b1;
						n.mem_valid = 1'b0;
						n.rw = 1'b1;
					end else begin
						n.mode = BBRI_RUN;
						n.ba = 1'b0;
						if (accept) begin
							n.busy = 1'b1;
							n.mem_valid = 1'b1;
							n.wr = cpu_req.write;
							n.rw = ~cpu_req.write;
							n.addr = cpu_req.addr;
							n.wdata = cpu_req.wdata;
						end
					end
				end
			end
			default: begin
				n.mode = BBRI_RUN;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.mode <= BBRI_RUN;
			r.step <= BBRI_STEP_LAST;
			r.rw <= 1'b1;
			r.ref_s1 <= 1'b1;
			r.ref_s2 <= 1'b1;
			r.halt_s1 <= 1'b1;
			r.halt_s2 <= 1'b1;
			r.addr <= BBRI_ADDR_RST;
			r.wdata <= BBRI_DATA_RST;
		end else begin
			r <= n;
		end
	end

	// Pin drive
	assign phase1 = r.phi1;
	assign phase2 = r.phi2;
	assign memory_clock = r.mclk;
	assign refresh_grant = r.grant;
	assign bus_available = r.ba;
	assign read_write = r.rw;
	assign valid_memory_address = r.mem_valid;
	assign cpu_rsp = r.rsp;
	assign addr_out = r.addr;
	// Address bus stays off while halted, a refresh in halt included
	assign addr_oe_n = r.ba;
	assign data_out = r.wdata;
	assign data_oe_n = ~(r.busy & r.wr);
	// User address line: driven from the jumper path or read from debug
	assign valid_user_address_out = r.mem_valid;
	assign valid_user_address_oe_n = r.dbg;
	assign user_address_valid = r.dbg ? r.uaddr_s2 : r.mem_valid;

	// Refresh entry and exit steps
	sequence ref_seen_s;
		!r.ref_s2 && boundary && r.mode != BBRI_REFRESH;
	endsequence
	sequence ref_entered_s;
		r.mode == BBRI_REFRESH && !phase1 && !phase2;
	endsequence
	sequence ref_left_s;
		!refresh_grant && r.mode == BBRI_RUN;
	endsequence

	write_dir_a: assert property (accept |=>
		(read_write == !$past(cpu_req.write)))
		else $error("direction line wrong for transfer");
	idle_read_a: assert property (!r.busy |-> read_write)
		else $error("direction line not high when idle");
	halt_read_a: assert property ((r.mode == BBRI_HALT) |->
		(read_write && bus_available && !valid_memory_address &&
		addr_oe_n && data_oe_n))
		else $error("halt bus state wrong");
	halt_dir_a: assert property (bus_available |-> read_write)
		else $error("direction line low while halted");
	user_addr_a: assert property (!r.dbg |->
		(!valid_user_address_oe_n &&
		user_address_valid == valid_memory_address &&
		valid_user_address_out == valid_memory_address))
		else $error("user address line not following valid address");
	dbg_input_a: assert property (r.dbg |->
		(valid_user_address_oe_n && user_address_valid == r.uaddr_s2))
		else $error("user address line not taken as input");
	ref_start_a: assert property (ref_seen_s |=>
		ref_entered_s ##1 (refresh_grant || $past(r.ref_s2)))
		else $error("refresh not started");
	phase_stop_a: assert property (refresh_grant |->
		(!phase1 && !phase2 && !$past(phase1) && !$past(phase2)))
		else $error("phases running during refresh");
	mclk_runs_a: assert property ((r.mode == BBRI_REFRESH) |=>
		(memory_clock != $past(memory_clock)))
		else $error("memory clock stopped");
	grant_end_a: assert property ((refresh_grant && r.ref_s2) |=>
		ref_left_s ##1 (phase1 || !$past(r.ref_s2)))
		else $error("refresh not ended after request release");
	grant_hold_a: assert property ((refresh_grant && !r.ref_s2) |=>
		refresh_grant)
		else $error("grant dropped while request held");
endmodule : bbri_core

/* File: core/bbri_pkg.sv */
// Constants and types shared by the board bus refresh interface
package bbri_pkg;
	// Bus widths
	localparam int BBRI_ADDR_W = 16;
	localparam int BBRI_DATA_W = 8;
	// Machine cycle of eight clock steps: phase one, gap, phase two, gap
	localparam logic [2:0] BBRI_STEP_LAST = 3'h7;
	localparam logic [2:0] BBRI_PHI1_FIRST = 3'h0;
	localparam logic [2:0] BBRI_PHI1_END = 3'h2;
	localparam logic [2:0] BBRI_PHI2_FIRST = 3'h4;
	localparam logic [2:0] BBRI_PHI2_END = 3'h6;
	// Cycles after reset release before the strap is caught
	localparam logic [1:0] BBRI_BOOT_CATCH = 2'h2;
	localparam logic [1:0] BBRI_BOOT_DONE = 2'h3;
	// Reset values
	localparam logic [BBRI_ADDR_W-1:0] BBRI_ADDR_RST = 16'h0000;
	localparam logic [BBRI_DATA_W-1:0] BBRI_DATA_RST = 8'h00;

	// Operating mode of the bus interface
	typedef enum logic [1:0] {
		BBRI_RUN,
		BBRI_REFRESH,
		BBRI_HALT
	} bbri_mode_t;

	// Processor side transfer request
	typedef struct packed {
		logic valid;
		logic write;
		logic [BBRI_ADDR_W-1:0] addr;
		logic [BBRI_DATA_W-1:0] wdata;
	} bbri_req_t;

	// Processor side transfer answer
	typedef struct packed {
		logic valid;
		logic [BBRI_DATA_W-1:0] rdata;
	} bbri_rsp_t;

	// Whole module state
	typedef struct packed {
		bbri_mode_t mode;
		logic [2:0] step;
		logic [1:0] boot;
		logic dbg;
		logic phi1;
		logic phi2;
		logic mclk;
		logic grant;
		logic busy;
		logic wr;
		logic rw;
		logic mem_valid;
		logic ba;
		logic [BBRI_ADDR_W-1:0] addr;
		logic [BBRI_DATA_W-1:0] wdata;
		bbri_rsp_t rsp;
		logic ref_s1;
		logic ref_s2;
		logic halt_s1;
		logic halt_s2;
		logic strap_s1;
		logic strap_s2;
		logic uaddr_s1;
		logic uaddr_s2;
		logic [BBRI_DATA_W-1:0] din_s1;
		logic [BBRI_DATA_W-1:0] din_s2;
	} bbri_state_t;
endpackage : bbri_pkg

/* File: test/bbri_mem_model.sv */
// Plug-in memory module model answering reads on the data bus
`timescale 1ns/1ns
module bbri_mem_model (
	// Clock
	input wire logic clk,
	// Bus from the board
	input wire logic [bbri_pkg::BBRI_ADDR_W-1:0] addr,
	input wire logic read_write,
	input wire logic valid_memory_address,
	input wire logic refresh_grant,
	// Data toward the board
	output logic [bbri_pkg::BBRI_DATA_W-1:0] data
);
	import bbri_pkg::*;
	logic [BBRI_DATA_W-1:0] last_r = 8'h00;
	// Drive read data, otherwise a changing pattern
	always_comb begin
		if (valid_memory_address && read_write && !refresh_grant) begin
			data = addr[7:0] ^ addr[15:8];
		end else begin
			data = ~last_r;
		end
	end
	// Remember last level seen
	always_ff @(posedge clk) begin
		last_r <= data;
	end
endmodule : bbri_mem_model

/* File: test/board_bus_refresh_interface_test.sv */
// Self-checking bench for the board bus refresh interface
`timescale 1ns/1ns
module board_bus_refresh_interface_test;
	import bbri_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, halt_n = 1'b1, strap = 1'b0, ref_n = 1'b1;
	bbri_req_t req = '0;
	bbri_rsp_t rsp;
	logic rdy, ph1, ph2, mclk, gnt, ba, rw, memv, uav, ua_out, ua_oe_n;
	logic ua_drv = 1'b0, aoe_n, doe_n, ua_pin, pm;
	logic [15:0] addr;
	logic [7:0] dout, mem_d, bus_d;
	int bad_count = 0;
	int n_checks = 0;
	int i;
	// Resolved pin levels
	assign ua_pin = ua_oe_n ? ua_drv : ua_out;
	assign bus_d = doe_n ? mem_d : dout;
	// Clock
	always #50 clk = ~clk;
	bbri_core uut (.clk(clk), .rst_n(rst_n), .cpu_req(req), .cpu_ready(rdy),
		.cpu_rsp(rsp), .phase1(ph1), .phase2(ph2), .memory_clock(mclk),
		.go_halt(halt_n), .debug_strap(strap), .refresh_request_n(ref_n),
		.refresh_grant(gnt), .bus_available(ba), .read_write(rw),
		.valid_memory_address(memv), .user_address_valid(uav),
		.valid_user_address_in(ua_pin), .valid_user_address_out(ua_out),
		.valid_user_address_oe_n(ua_oe_n), .addr_out(addr),
		.addr_oe_n(aoe_n), .data_in(bus_d), .data_out(dout),
		.data_oe_n(doe_n));
	bbri_mem_model mem (.clk(clk), .addr(addr), .read_write(rw),
		.valid_memory_address(memv), .refresh_grant(gnt), .data(mem_d));
	// Compare and count
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	// Verdict and end of run
	task automatic final_report;
		$display("Checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : final_report
	// One processor transfer with bus checks
	task automatic xfer(input logic wr, input logic [15:0] a,
		input logic [7:0] d);
		int k;
		@(negedge clk);
		req = '{1'b1, wr, a, d};
		for (k = 0; k < 40 && rdy !== 1'b1; k++) @(negedge clk);
		@(negedge clk);
		req.valid = 1'b0;
		check({rw, memv, doe_n, aoe_n}, {!wr, 1'b1, !wr, 1'b0});
		check(addr, a);
		check({ua_out, uav}, 2'b11);
		if (wr) check(dout, d);
		for (k = 0; k < 12 && rsp.valid !== 1'b1; k++) @(negedge clk);
		check(k < 12, 1'b1);
		if (!wr) check(rsp.rdata, a[7:0] ^ a[15:8]);
		@(negedge clk);
		check({rw, memv}, 2'b10);
	endtask : xfer
	// Main sequence
	initial begin
		void'($urandom(32852));
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		check({rw, ua_oe_n, uav}, {1'b1, 1'b0, memv});
		xfer(1'b1, 16'hffff, 8'ha5);
		xfer(1'b0, 16'hffff, 8'h00);
		xfer(1'b0, 16'h0001, 8'h00);
		repeat (6) xfer(1'($urandom), 16'($urandom), 8'($urandom));
		// Refresh: phases stop, memory clock runs
		ref_n = 1'b0;
		for (i = 0; i < 20 && gnt !== 1'b1; i++) @(negedge clk);
		check(gnt, 1'b1);
		repeat (5) begin
			pm = mclk;
			check({ph1, ph2, rdy}, 3'b000);
			@(negedge clk);
			check(mclk, !pm);
		end
		ref_n = 1'b1;
		for (i = 0; i < 8 && gnt !== 1'b0; i++) begin
			check({ph1, ph2}, 2'b00);
			@(negedge clk);
		end
		check(gnt, 1'b0);
		for (i = 0; i < 8 && ph1 !== 1'b1; i++) @(negedge clk);
		check(ph1, 1'b1);
		for (i = 0; i < 8 && ph2 !== 1'b1; i++) @(negedge clk);
		check({ph1, ph2}, 2'b01);
		// Halt: buses released, direction reads
		halt_n = 1'b0;
		for (i = 0; i < 20 && ba !== 1'b1; i++) @(negedge clk);
		check({ba, memv, rw, aoe_n, rdy}, 5'h16);
		halt_n = 1'b1;
		xfer(1'b0, 16'h8000, 8'h00);
		// Debug strap fitted: user address line is an input
		strap = 1'b1;
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		for (i = 0; i < 4; i++) begin
			ua_drv = (i == 0) ? 1'b1 : 1'($urandom);
			repeat (4) @(negedge clk);
			check({ua_oe_n, uav}, {1'b1, ua_drv});
		end
		final_report();
	end
	// Watchdog
	initial begin
		#3000000;
		bad_count++;
		final_report();
	end
endmodule : board_bus_refresh_interface_test
